// ---- rtl/sbc_ctl_regs.svh ----
// How it works
// - Power-clock strap high and power state D3 put the downstream bus into B2.
// - In B2 every downstream clock output stops and rests at 0.
// - Power-clock strap low keeps downstream clocks running even in D3.
// - Fast operation only with the fast-capable strap high, else 33 MHz only.
// - Upstream fast-enable low: pull the downstream fast-enable line low.
// - Upstream fast-enable high with fast-capable strap high: downstream line is an input, pulled up or down outside.
// - The downstream fast-enable line is open drain, never driven high.
// - 66 MHz upstream with 33 MHz downstream: clocks are the bus clock divided by 2.
// - Only 66/66, 66/33 and 33/33; never 33 upstream with 66 downstream.
`ifndef SBC_CTL_REGS_SVH
`define SBC_CTL_REGS_SVH

// ==========================================================
// Register map
`define SBC_PM_CTL_OFS       12'h000
`define SBC_SPEED_STAT_OFS   12'h004
`define SBC_PM_CTL_RST       2'h0

// ==========================================================
// Speed status fields
`define SBC_ST_FAST_CAP      0
`define SBC_ST_UP_FAST       1
`define SBC_ST_DS_FAST       2
`define SBC_ST_DIV_MODE      3
`define SBC_ST_STOPPED       4
`define SBC_ST_PWR_STRAP     5
`define SBC_ST_PULL_LOW      6

// ==========================================================
// Pin sampling and clocking
`define SBC_PIN_RST          4'h0
`define SBC_CLK_DIV          2

`endif

// ---- rtl/sbc_ctl_pkg.sv ----
package sbc_ctl_pkg;

   typedef logic [11:0] apb_addr_t;
   typedef logic [31:0] apb_data_t;

   typedef enum logic [1:0]
   {
      PWR_D0,
      PWR_D1,
      PWR_D2,
      PWR_D3
   } pwr_state_e;

   typedef struct packed
   {
      logic pull_low;
      logic pwr_strap;
      logic stopped;
      logic div_mode;
      logic ds_fast;
      logic up_fast;
      logic fast_cap;
   } speed_s;

endpackage

// ---- rtl/sbc_ctl.sv ----
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "sbc_ctl_regs.svh"

module sbc_ctl
#(
   parameter int NUM_CLK = 10
)
(
   input  wire logic                 REF_CLK,
   input  wire logic                 RESET,
   input  wire logic                 PSEL,
   input  wire logic                 PENABLE,
   input  wire logic                 PWRITE,
   input  wire sbc_ctl_pkg::apb_addr_t PADDR,
   input  wire sbc_ctl_pkg::apb_data_t PWDATA,
   output      sbc_ctl_pkg::apb_data_t PRDATA,
   output      logic                 PREADY,
   output      logic                 PSLVERR,
   input  wire logic                 BUS_POWER_CLOCK_CTL_STRAP,
   input  wire logic                 FAST_CAPABLE_STRAP,
   input  wire logic                 UPSTREAM_FAST_ENABLE,
   input  wire logic                 DOWNSTREAM_FAST_ENABLE_I,
   output      logic                 DOWNSTREAM_FAST_ENABLE_O,
   output      logic                 DOWNSTREAM_FAST_ENABLE_OE,
   output      logic [NUM_CLK-1:0]   DOWNSTREAM_CLOCK_OUTPUTS
);
   import sbc_ctl_pkg::*;

   // ==========================================================
   // Pin synchronisers
   logic [3:0]  sync1_r;
   logic [3:0]  sync2_r;
   logic [3:0]  sync3_r;
   logic [3:0]  pin_r;
   logic        pwr_strap;
   logic        fast_cap;
   logic        up_fast;
   logic        ds_line;

   // A bit moves only once the last two stages agree
   function automatic logic [3:0] settle(input logic [3:0] a, input logic [3:0] b,
                                         input logic [3:0] old);
      settle = (a & b) | (old & (a ^ b));
   endfunction

   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         sync1_r <= `SBC_PIN_RST;
         sync2_r <= `SBC_PIN_RST;
         sync3_r <= `SBC_PIN_RST;
         pin_r   <= `SBC_PIN_RST;
      end
      else
      begin
         sync1_r <= {BUS_POWER_CLOCK_CTL_STRAP, FAST_CAPABLE_STRAP,
                     UPSTREAM_FAST_ENABLE, DOWNSTREAM_FAST_ENABLE_I};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         pin_r   <= settle(sync2_r, sync3_r, pin_r);
      end
   end

   assign pwr_strap = pin_r[3];
   assign fast_cap  = pin_r[2];
   assign up_fast   = pin_r[1];
   assign ds_line   = pin_r[0];

   // ==========================================================
   // Register file
   pwr_state_e  pm_state_r;
   logic        setup;
   logic        hit_pm;
   logic        hit_stat;
   speed_s      stat;

   assign setup    = PSEL && !PENABLE;
   assign hit_pm   = PADDR == `SBC_PM_CTL_OFS;
   assign hit_stat = PADDR == `SBC_SPEED_STAT_OFS;

   // Writes land at the access edge only
   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
         pm_state_r <= pwr_state_e'(`SBC_PM_CTL_RST);
      else if (PSEL && PENABLE && PWRITE && hit_pm)
         pm_state_r <= pwr_state_e'(PWDATA[1:0]);
   end

   // Read data captured in setup so the access phase needs no wait
   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         PRDATA  <= '0;
         PSLVERR <= 1'b0;
      end
      else if (setup)
      begin
         PSLVERR <= !(hit_pm || hit_stat);
         if (PWRITE)
            PRDATA <= '0;
         else if (hit_pm)
            PRDATA <= {30'h0000_0000, pm_state_r};
         else if (hit_stat)
            PRDATA <= {25'h000_0000, stat};
         else
            PRDATA <= '0;
      end
   end

   assign PREADY = 1'b1;

   // ==========================================================
   // Speed selection
   logic        eff_up;
   logic        pull_low_r;
   logic        div_mode_r;
   logic        stop_r;

   assign eff_up = fast_cap && up_fast;

   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         pull_low_r <= 1'b1;
         div_mode_r <= 1'b0;
      end
      else
      begin
         pull_low_r <= !eff_up;
         div_mode_r <= eff_up && !ds_line;
      end
   end

   // Open drain: data is always low, only the enable moves
   assign DOWNSTREAM_FAST_ENABLE_O  = 1'b0;
   assign DOWNSTREAM_FAST_ENABLE_OE = pull_low_r;

   // ==========================================================
   // Power state to bus state
   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
         stop_r <= 1'b0;
      else
         stop_r <= pwr_strap && (pm_state_r == PWR_D3);
   end

   assign stat = '{pull_low: pull_low_r, pwr_strap: pwr_strap, stopped: stop_r,
                   div_mode: div_mode_r, ds_fast: eff_up && ds_line,
                   up_fast: up_fast, fast_cap: fast_cap};

   // ==========================================================
   // Clock generation
   logic        div_r;
   logic        run_neg_r;
   logic        mode_neg_r;
   logic        clk_src;

   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
         div_r <= 1'b0;
      else
         div_r <= div_mode_r ? !div_r : 1'b0;
   end

   // Gate moves on the falling edge, and in divide mode only while
   // the divided clock is low, so no output pulse is ever cut short
   always_ff @(negedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         run_neg_r  <= 1'b1;
         mode_neg_r <= 1'b0;
      end
      else if (!div_r)
      begin
         run_neg_r  <= !stop_r;
         mode_neg_r <= div_mode_r;
      end
   end

   assign clk_src = mode_neg_r ? div_r : REF_CLK;
   assign DOWNSTREAM_CLOCK_OUTPUTS = {NUM_CLK{run_neg_r && clk_src}};

   // ==========================================================
   // Checks
   a_d3_stops_bus: assert property (@(posedge REF_CLK) disable iff (RESET)
      (pwr_strap && pm_state_r == PWR_D3) |-> ##[1:4] !run_neg_r)
      else $error("D3 with strap high did not stop clocks");

   a_stopped_low: assert property (@(posedge REF_CLK) disable iff (RESET)
      stop_r [*4] |-> DOWNSTREAM_CLOCK_OUTPUTS == '0)
      else $error("Stopped clocks not held low");

   a_strap_low_runs: assert property (@(posedge REF_CLK) disable iff (RESET)
      !pwr_strap [*4] |-> run_neg_r)
      else $error("Clocks stopped with strap low");

   a_slow_only_cap: assert property (@(posedge REF_CLK) disable iff (RESET)
      !fast_cap [*2] |-> DOWNSTREAM_FAST_ENABLE_OE && !div_mode_r)
      else $error("Fast mode without capable strap");

   a_up_slow_pulls: assert property (@(posedge REF_CLK) disable iff (RESET)
      !up_fast |=> DOWNSTREAM_FAST_ENABLE_OE)
      else $error("Downstream line not pulled low");

   a_line_is_input: assert property (@(posedge REF_CLK) disable iff (RESET)
      (fast_cap && up_fast) |=> !DOWNSTREAM_FAST_ENABLE_OE && (div_mode_r == !$past(ds_line)))
      else $error("Downstream line not treated as input");

   a_open_drain: assert property (@(posedge REF_CLK) disable iff (RESET)
      DOWNSTREAM_FAST_ENABLE_OE |-> !DOWNSTREAM_FAST_ENABLE_O)
      else $error("Downstream line driven high");

   a_half_rate: assert property (@(posedge REF_CLK) disable iff (RESET)
      (div_mode_r && $past(div_mode_r)) |-> div_r != $past(div_r))
      else $error("Divider not toggling");

   a_no_slow_up: assert property (@(posedge REF_CLK) disable iff (RESET)
      div_mode_r |-> $past(fast_cap && up_fast))
      else $error("Divide mode with slow upstream");

   a_restart: assert property (@(posedge REF_CLK) disable iff (RESET)
      $fell(stop_r) |-> ##[1:3] run_neg_r)
      else $error("Clocks did not restart after D3");

endmodule

// ---- tb/sbc_board.sv ----
`timescale 1ns/100ps
module sbc_board
(
   input  wire logic pull_up,
   input  wire logic drv_o,
   input  wire logic drv_oe,
   output      logic line
);
   // Board resistor wins unless the bridge pulls low
   assign line = drv_oe ? drv_o : pull_up;
endmodule

// ---- tb/secondary_bus_clock_speed_control_test.sv ----
`timescale 1ns/100ps
module secondary_bus_clock_speed_control_test;
   import sbc_ctl_pkg::*;
   localparam int N = 4;
   logic         ref_clk, reset, psel, penable, pwrite, pready, pslverr;
   logic         pwr_strap, cap, up, pull_up, line, o, oe;
   apb_addr_t    paddr;
   apb_data_t    pwdata, prdata;
   logic [N-1:0] clks;
   logic [32:0]  exp_q[$];
   int           failures, tests_run, seed, n;

   sbc_ctl #(.NUM_CLK(N)) dut (.REF_CLK(ref_clk), .RESET(reset), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .BUS_POWER_CLOCK_CTL_STRAP(pwr_strap), .FAST_CAPABLE_STRAP(cap),
      .UPSTREAM_FAST_ENABLE(up), .DOWNSTREAM_FAST_ENABLE_I(line),
      .DOWNSTREAM_FAST_ENABLE_O(o), .DOWNSTREAM_FAST_ENABLE_OE(oe),
      .DOWNSTREAM_CLOCK_OUTPUTS(clks));
   sbc_board board (.pull_up(pull_up), .drv_o(o), .drv_oe(oe), .line(line));

   initial
   begin
      ref_clk = 0;
      forever #10 ref_clk = ~ref_clk;
   end

   // ==========================================
   // Checking
   task finish_test;
      if (failures == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task cmp_rd(input logic [32:0] got, input logic [32:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task cmp_pin(input logic [7:0] got, input logic [7:0] exp);
      cmp_rd({25'h0, got}, {25'h0, exp});
   endtask

   // Every response is judged at the sampling edge, in request order
   always @(posedge ref_clk)
      if (psel && penable && pready && exp_q.size() > 0)
         cmp_rd({pslverr, prdata}, exp_q.pop_front());

   // ==========================================
   // Drivers
   task apb(input logic wr, input apb_addr_t a, input apb_data_t d);
      int k;
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      k = 0;
      do
      begin
         @(posedge ref_clk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         failures++;
         finish_test();
      end
      psel <= 0;
      penable <= 0;
      // Extra edge so the next setup never reassigns in this step
      @(posedge ref_clk);
   endtask

   task rd(input apb_addr_t a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(0, a, 32'h0);
   endtask

   // Writes answer with zero data; only the error flag varies
   task wr_reg(input apb_addr_t a, input apb_data_t d, input logic err);
      exp_q.push_back({err, 32'h0});
      apb(1, a, d);
   endtask

   task set_pins(input logic c, input logic u, input logic p);
      cap <= c;
      up <= u;
      pull_up <= p;
      repeat (8) @(posedge ref_clk);
   endtask

   // 0 stopped, 1 half rate, 2 full rate over 20 bus clocks
   task clk_class(input logic [7:0] e);
      n = 0;
      fork
         repeat (20) @(posedge ref_clk);
         forever @(posedge clks[0]) n++;
      join_any
      disable fork;
      cmp_pin((n == 0) ? 8'h0 : (n < 15) ? 8'h1 : 8'h2, e);
   endtask

   function automatic apb_data_t stat(input logic c, u, p, s, stop);
      speed_s x;
      x = '{pull_low: !(c & u), pwr_strap: s, stopped: stop, div_mode: c & u & !p,
            ds_fast: c & u & p, up_fast: u, fast_cap: c};
      return 32'(x);
   endfunction

   // ==========================================
   // Scenarios
   initial
   begin
      seed = 32'he5477165;
      failures = 0;
      tests_run = 0;
      {reset, pwr_strap, cap, up, pull_up} = 5'h1f;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (4) @(posedge ref_clk);
      reset <= 0;
      @(posedge ref_clk);
      for (int i = 0; i < 8; i++)
      begin
         set_pins(i[2], i[1], i[0]);
         cmp_pin({6'h0, o, oe}, {7'h0, !(i[2] & i[1])});
         rd(12'h004, {1'b0, stat(i[2], i[1], i[0], 1, 0)});
         clk_class((i[2] & i[1] & !i[0]) ? 8'h1 : 8'h2);
      end
      set_pins(1, 1, 0);
      wr_reg(12'h000, 32'h3, 1'b0);
      repeat (6) @(posedge ref_clk);
      clk_class(8'h0);
      cmp_pin(8'(clks), 8'h0);
      rd(12'h000, {1'b0, 32'h3});
      rd(12'h004, {1'b0, stat(1, 1, 0, 1, 1)});
      wr_reg(12'h004, $random(seed), 1'b0);
      wr_reg(12'h00c, $random(seed), 1'b1);
      rd(12'h000, {1'b0, 32'h3});
      rd(12'h004, {1'b0, stat(1, 1, 0, 1, 1)});
      rd(12'h008, {1'b1, 32'h0});
      wr_reg(12'h000, 32'h0, 1'b0);
      repeat (6) @(posedge ref_clk);
      clk_class(8'h1);
      pwr_strap <= 0;
      set_pins(1, 1, 1);
      wr_reg(12'h000, 32'h3, 1'b0);
      repeat (6) @(posedge ref_clk);
      clk_class(8'h2);
      rd(12'h004, {1'b0, stat(1, 1, 1, 0, 0)});
      finish_test();
   end
endmodule
